// File: src/mad_master_decoder.sv
// Master address decoder, control latch and slave-bus window arbiter.
//
// Contract
// - Master controls slave reset, interrupt, audio mute.
// - Slave reaches DSP store only via bus.
// - 32K ROM decoded in master space only.
// - All 16K RAM reachable from master space.
// - Slave sees only upper 4K shared RAM.
// - Lower 4K never selected on slave cycles.
// - DSP 1K store decoded for both processors.
// - Slave refresh period is the master window.
// - Master slave-bus access only inside refresh, or any time while slave is held in reset.
// - Memory bits 15-13, I/O bits 7-5.
// - ROM, local RAM, shared, DSP address ranges.
// - I/O read selects and UART select.
// - Port 60h write loads control latch.
// - Wait master outside window until next window.
// - Slave in reset: grant without wait.
module mad_master_decoder (
   // Clock and reset
   input  wire logic                       i_core_clk,
   input  wire logic                       i_resetn,
   // Master processor bus
   input  wire logic [mad_pkg::ADDR_W-1:0] i_master_address_bus,
   input  wire logic [mad_pkg::DATA_W-1:0] i_master_data_bus,
   input  wire logic                       i_master_memory_request_n,
   input  wire logic                       i_master_io_request_n,
   input  wire logic                       i_master_rd_n,
   input  wire logic                       i_master_wr_n,
   input  wire logic                       i_master_m1_n,
   input  wire logic                       i_master_refresh_n,
   // Slave processor bus
   input  wire logic [mad_pkg::ADDR_W-1:0] i_slave_address_bus,
   input  wire logic                       i_slave_memory_request_n,
   input  wire logic                       i_slave_refresh_n,
   // Master memory selects
   output      logic                       o_rom_select_n,
   output      logic                       o_local_ram_select_n,
   output      logic                       o_master_slavebus_request_n,
   output      logic                       o_master_wait_n,
   // Slave bus selects
   output      logic                       o_slave_bus_grant,
   output      logic                       o_shared_ram_select_n,
   output      logic                       o_dsp_store_select_n,
   // Master I/O selects
   output      logic                       o_input_port_a_select_n,
   output      logic                       o_input_port_b_select_n,
   output      logic                       o_input_port_c_select,
   output      logic                       o_uart_select_n,
   // Control latch outputs
   output      logic                       o_slave_sync_n,
   output      logic                       o_audio_mute_n,
   output      logic                       o_slave_reset_n,
   output      logic [mad_pkg::LED_W-1:0]  o_midi_led
);
   import mad_pkg::*;

   logic                 mem_cycle;
   logic                 io_cycle;
   logic                 io_read;
   logic [M_NUM-1:0]     m_hit;
   logic [S_NUM-1:0]     s_hit;
   logic                 slave_cycle;
   logic                 window;
   logic                 slave_in_reset;
   logic                 req_d;
   logic                 latch_wr;
   logic [DATA_W-1:0]    ctl_q;
   mad_win_state_t       state_q;
   mad_win_state_t       state_d;
   logic [1:0]           grant_cnt_q;
   logic [1:0]           grant_cnt_d;

   // Master refresh cycles also drive memory request; they must not select
   assign mem_cycle = !i_master_memory_request_n && i_master_refresh_n;
   // Interrupt acknowledge carries I/O request with M1; it is not a port access
   assign io_cycle  = !i_master_io_request_n && i_master_m1_n;
   assign io_read   = io_cycle && !i_master_rd_n;

   genvar gi;
   generate
      for (gi = 0; gi < M_NUM; gi++) begin : g_master
         mad_region_match #(
            .MASK (M_MASK[gi]),
            .BASE (M_BASE[gi])
         ) u_match (
            .i_addr   (i_master_address_bus),
            .i_enable ((gi < M_IO_A) ? mem_cycle : io_cycle),
            .o_match  (m_hit[gi])
         );
      end
      for (gi = 0; gi < S_NUM; gi++) begin : g_slave
         mad_region_match #(
            .MASK (S_MASK[gi]),
            .BASE (S_BASE[gi])
         ) u_match (
            .i_addr   (i_slave_address_bus),
            .i_enable (slave_cycle),
            .o_match  (s_hit[gi])
         );
      end
   endgenerate

   // Slave's own cycles exclude its refresh, which belongs to the master
   assign slave_cycle    = !i_slave_memory_request_n && i_slave_refresh_n;
   assign window         = !i_slave_refresh_n;
   assign slave_in_reset = !ctl_q[CTL_RST_BIT];
   assign req_d          = m_hit[M_SHARE] || m_hit[M_DSP];
   assign latch_wr       = m_hit[M_IO_CT] && !i_master_wr_n;

   // ROM and local RAM live on the master bus only
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rom_select_n <= 1'b1;
      end else begin
         o_rom_select_n <= !m_hit[M_ROM];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_local_ram_select_n <= 1'b1;
      end else begin
         o_local_ram_select_n <= !m_hit[M_LRAM];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_master_slavebus_request_n <= 1'b1;
      end else begin
         o_master_slavebus_request_n <= !req_d;
      end
   end

   // Read-only ports respond only with read strobe low
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_input_port_a_select_n <= 1'b1;
      end else begin
         o_input_port_a_select_n <= !(m_hit[M_IO_A] && io_read);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_input_port_b_select_n <= 1'b1;
      end else begin
         o_input_port_b_select_n <= !(m_hit[M_IO_B] && io_read);
      end
   end

   // Port c select is active high, so its idle level is low
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_input_port_c_select <= 1'b0;
      end else begin
         o_input_port_c_select <= m_hit[M_IO_C] && io_read;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_uart_select_n <= 1'b1;
      end else begin
         o_uart_select_n <= !m_hit[M_UART];
      end
   end

   // Reset leaves the slave held and audio muted until software releases them
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctl_q <= CTL_RESET;
      end else if (latch_wr) begin
         ctl_q <= i_master_data_bus;
      end
   end

   // Pins trail the latch by one cycle so every output comes from a flop
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_slave_sync_n <= CTL_RESET[CTL_SYNC_BIT];
      end else begin
         o_slave_sync_n <= ctl_q[CTL_SYNC_BIT];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_audio_mute_n <= CTL_RESET[CTL_MUTE_BIT];
      end else begin
         o_audio_mute_n <= ctl_q[CTL_MUTE_BIT];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_slave_reset_n <= CTL_RESET[CTL_RST_BIT];
      end else begin
         o_slave_reset_n <= ctl_q[CTL_RST_BIT];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_midi_led <= CTL_RESET[CTL_LED_HI:CTL_LED_LO];
      end else begin
         o_midi_led <= ctl_q[CTL_LED_HI:CTL_LED_LO];
      end
   end

   // Window arbiter: DONE keeps one master cycle from being granted twice
   always_comb begin
      state_d     = state_q;
      grant_cnt_d = grant_cnt_q;
      case (state_q)
         WIN_IDLE: begin
            if (req_d && (slave_in_reset || window)) begin
               state_d     = WIN_GRANT;
               grant_cnt_d = 2'h0;
            end else if (req_d) begin
               state_d = WIN_WAIT;
            end
         end
         WIN_WAIT: begin
            if (!req_d) begin
               state_d = WIN_IDLE;
            end else if (slave_in_reset || window) begin
               state_d     = WIN_GRANT;
               grant_cnt_d = 2'h0;
            end
         end
         WIN_GRANT: begin
            if (!req_d) begin
               state_d = WIN_IDLE;
            end else if (!slave_in_reset &&
                         (!window || grant_cnt_q == REFRESH_CNT - 2'h1)) begin
               state_d = WIN_DONE;
            end else if (grant_cnt_q != REFRESH_CNT) begin
               grant_cnt_d = grant_cnt_q + 2'h1;
            end
         end
         WIN_DONE: begin
            if (!req_d) begin
               state_d = WIN_IDLE;
            end
         end
         default: begin
            state_d = WIN_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= WIN_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Count is only meaningful in GRANT; it is cleared on every entry
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         grant_cnt_q <= 2'h0;
      end else begin
         grant_cnt_q <= grant_cnt_d;
      end
   end

   // Wait is driven from the next state so it lands in the request's own cycle
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_master_wait_n <= 1'b1;
      end else begin
         o_master_wait_n <= !(req_d && state_d == WIN_WAIT);
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_slave_bus_grant <= 1'b0;
      end else begin
         o_slave_bus_grant <= (state_d == WIN_GRANT);
      end
   end

   // Granted master sees all 8K of shared RAM; the slave only the upper 4K
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_shared_ram_select_n <= 1'b1;
      end else if (state_d == WIN_GRANT) begin
         o_shared_ram_select_n <= !m_hit[M_SHARE];
      end else begin
         o_shared_ram_select_n <= !s_hit[S_SHARE];
      end
   end

   // Slave reaches the DSP store only through this select on its own bus
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_dsp_store_select_n <= 1'b1;
      end else if (state_d == WIN_GRANT) begin
         o_dsp_store_select_n <= !m_hit[M_DSP];
      end else begin
         o_dsp_store_select_n <= !s_hit[S_DSP];
      end
   end

endmodule

// File: shared/mad_pkg.sv
// Package of constants and types for the master address decoder.
package mad_pkg;

   // Bus widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned LED_W  = 2;

   // Master-side match table indices
   localparam int unsigned M_ROM   = 0;
   localparam int unsigned M_LRAM  = 1;
   localparam int unsigned M_SHARE = 2;
   localparam int unsigned M_DSP   = 3;
   localparam int unsigned M_IO_A  = 4;
   localparam int unsigned M_IO_B  = 5;
   localparam int unsigned M_IO_C  = 6;
   localparam int unsigned M_IO_CT = 7;
   localparam int unsigned M_UART  = 8;
   localparam int unsigned M_NUM   = 9;

   // Memory decodes look at address bits 15..13 (DSP store narrows to 1K)
   localparam logic [15:0] M_MASK [M_NUM] = '{
      16'h8000, 16'hE000, 16'hE000, 16'hFC00,
      16'h00E0, 16'h00E0, 16'h00E0, 16'h00E0, 16'h00E0};
   localparam logic [15:0] M_BASE [M_NUM] = '{
      16'h0000, 16'hA000, 16'hC000, 16'hE000,
      16'h0000, 16'h0020, 16'h0040, 16'h0060, 16'h0080};

   // Slave-side match table: upper 4K of shared RAM and the DSP store
   localparam int unsigned S_SHARE = 0;
   localparam int unsigned S_DSP   = 1;
   localparam int unsigned S_NUM   = 2;
   localparam logic [15:0] S_MASK [S_NUM] = '{16'hF000, 16'hFC00};
   localparam logic [15:0] S_BASE [S_NUM] = '{16'hD000, 16'hE000};

   // Control latch field positions and reset value
   localparam int unsigned CTL_SYNC_BIT = 0;
   localparam int unsigned CTL_MUTE_BIT = 1;
   localparam int unsigned CTL_RST_BIT  = 2;
   localparam int unsigned CTL_LED_LO   = 3;
   localparam int unsigned CTL_LED_HI   = 4;
   localparam logic [7:0]  CTL_RESET    = 8'h01;

   // Slave refresh window length in clock cycles
   localparam int unsigned REFRESH_CYCLES = 2;
   localparam logic [1:0]  REFRESH_CNT    = 2'(REFRESH_CYCLES);

   // Slave-bus window arbiter states
   typedef enum logic [1:0] {
      WIN_IDLE  = 2'b00,
      WIN_WAIT  = 2'b01,
      WIN_GRANT = 2'b10,
      WIN_DONE  = 2'b11
   } mad_win_state_t;

endpackage

// File: src/mad_region_match.sv
// Address window comparator used for every decoded range.
module mad_region_match #(
   parameter logic [15:0] MASK = 16'hFFFF,
   parameter logic [15:0] BASE = 16'h0000
) (
   // Address and qualifier
   input  wire logic [mad_pkg::ADDR_W-1:0] i_addr,
   input  wire logic                       i_enable,
   // Result
   output      logic                       o_match
);
   import mad_pkg::*;

   assign o_match = i_enable && ((i_addr & MASK) == BASE);

endmodule

// File: sim/mad_master_decoder_properties.sv
// Concurrent checks on the master address decoder ports.
module mad_master_decoder_properties (
   // Clock, reset, master bus and slave address bus
   input wire logic        i_core_clk, i_resetn, i_master_memory_request_n, i_master_io_request_n,
   input wire logic        i_master_rd_n, i_master_wr_n, i_master_m1_n, i_master_refresh_n,
   input wire logic [15:0] i_master_address_bus, i_slave_address_bus,
   input wire logic [7:0]  i_master_data_bus,
   // Slave bus and outputs
   input wire logic        i_slave_memory_request_n, i_slave_refresh_n, o_rom_select_n, o_local_ram_select_n,
   input wire logic        o_master_slavebus_request_n, o_master_wait_n, o_slave_bus_grant, o_shared_ram_select_n,
   input wire logic        o_input_port_a_select_n, o_input_port_b_select_n, o_input_port_c_select,
   input wire logic        o_dsp_store_select_n,
   input wire logic        o_uart_select_n, o_slave_sync_n, o_audio_mute_n, o_slave_reset_n,
   input wire logic [1:0]  o_midi_led
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] ma, ia;
   logic       mem, io, sreq, wr_ev;
   assign ma = i_master_address_bus[15:13];
   assign ia = i_master_address_bus[7:5];
   assign mem = !i_master_memory_request_n && i_master_refresh_n;
   assign io = !i_master_io_request_n && i_master_m1_n;
   assign sreq = mem && (ma == 3'h6 || i_master_address_bus[15:10] == 6'h38);
   assign wr_ev = io && !i_master_wr_n && ia == 3'h3;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   a_rom_select: assert property (mem && !i_master_address_bus[15] |=> !o_rom_select_n)
      else $error("rom select missing");
   a_lram_select: assert property (mem && ma == 3'h5 |=> !o_local_ram_select_n)
      else $error("local ram select missing");
   a_slave_request: assert property (sreq |=> !o_master_slavebus_request_n)
      else $error("slave bus request missing");
   a_idle_quiet: assert property (i_master_memory_request_n && i_master_io_request_n |=>
      &{o_rom_select_n, o_local_ram_select_n, o_master_slavebus_request_n, o_input_port_a_select_n,
        o_input_port_b_select_n, !o_input_port_c_select, o_uart_select_n}) else $error("select without cycle");
   a_port_a_read: assert property (io && !i_master_rd_n && ia == 3'h0 |=> !o_input_port_a_select_n)
      else $error("port a select missing");
   a_port_c_high: assert property (io && !i_master_rd_n && ia == 3'h2 |=> o_input_port_c_select)
      else $error("port c select missing");
   a_uart_select: assert property (io && ia == 3'h4 |=> !o_uart_select_n)
      else $error("uart select missing");
   a_latch_load: assert property (wr_ev |-> ##2 {o_slave_reset_n, o_audio_mute_n, o_slave_sync_n, o_midi_led}
      == {$past(i_master_data_bus[2:0], 2), $past(i_master_data_bus[4:3], 2)}) else $error("latch load wrong");
   a_latch_hold: assert property (!$past(wr_ev, 2) |->
      $stable({o_slave_reset_n, o_audio_mute_n, o_slave_sync_n, o_midi_led})) else $error("latch drifted");
   a_grant_in_window: assert property (o_slave_bus_grant && o_slave_reset_n && $past(o_slave_reset_n, 2)
      |-> $past(!i_slave_refresh_n)) else $error("grant outside refresh");
   // The reset pin trails the latch by a cycle, so a write just before hides the real state
   a_reset_no_wait: assert property (sreq && !o_slave_reset_n && !$past(wr_ev)
      |=> o_master_wait_n && o_slave_bus_grant) else $error("wait while slave in reset");
   a_wait_outside: assert property (sreq && !$past(sreq) && i_slave_refresh_n && o_slave_reset_n
      && $past(o_slave_reset_n) && !$past(wr_ev) |=> !o_master_wait_n) else $error("no wait outside window");
   // The slave model refreshes every 8 cycles, so 12 is a safe ceiling
   a_wait_bounded: assert property ($fell(o_master_wait_n) |-> ##[1:12] o_master_wait_n)
      else $error("wait never ended");
   a_lower_hidden: assert property (!i_slave_memory_request_n && i_slave_refresh_n
      && i_slave_address_bus[15:12] == 4'hC |=> o_shared_ram_select_n || o_slave_bus_grant)
      else $error("lower shared ram seen by slave");
   a_upper_visible: assert property (!i_slave_memory_request_n && i_slave_refresh_n
      && i_slave_address_bus[15:12] == 4'hD |=> !o_shared_ram_select_n || o_slave_bus_grant)
      else $error("upper shared ram not selected for slave");
   a_dsp_slave_select: assert property (!i_slave_memory_request_n && i_slave_refresh_n
      && i_slave_address_bus[15:10] == 6'h38 |=> !o_dsp_store_select_n || o_slave_bus_grant)
      else $error("dsp store not selected for slave");
endmodule

// File: sim/mad_slave_cpu_model.sv
// Slave processor bus model: fetch cycles with a two-cycle refresh.
module mad_slave_cpu_model (
   // Clock and run control
   input  wire logic        i_core_clk,
   input  wire logic        i_slave_reset_n,
   // Slave bus
   output      logic [15:0] o_addr,
   output      logic        o_mreq_n,
   output      logic        o_refresh_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt_q = 3'h0;
   initial begin
      o_addr = 16'h0000;
      o_mreq_n = 1'b1;
      o_refresh_n = 1'b1;
   end
   always @(negedge i_core_clk) begin
      // Held in reset the slave never runs code the master has not loaded
      cnt_q <= i_slave_reset_n ? cnt_q + 3'h1 : 3'h0;
      o_refresh_n <= !(i_slave_reset_n && (cnt_q == 3'h5 || cnt_q == 3'h6));
      o_mreq_n <= !i_slave_reset_n || cnt_q == 3'h7;
      // Lower-bank, upper-bank and DSP addresses in turn, released bus shows inverted value
      o_addr <= (cnt_q == 3'h7) ? ~o_addr :
                (cnt_q == 3'h3) ? 16'hE003 : (cnt_q[0] ? 16'hD000 : 16'hC000) + 16'(cnt_q);
   end
endmodule

// File: sim/mad_master_decoder_tb.sv
// Self-checking bench for the master address decoder.
module mad_master_decoder_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mad_pkg::*;
   logic        i_core_clk = 1'b0, i_resetn = 1'b0, i_master_memory_request_n = 1'b1;
   logic        i_master_io_request_n = 1'b1, i_master_rd_n = 1'b1, i_master_wr_n = 1'b1;
   logic        i_master_m1_n = 1'b1, i_master_refresh_n = 1'b1, i_slave_memory_request_n, i_slave_refresh_n;
   logic [15:0] i_master_address_bus = 16'h0000, i_slave_address_bus;
   logic [7:0]  i_master_data_bus = 8'h00;
   logic        o_rom_select_n, o_local_ram_select_n, o_master_slavebus_request_n, o_master_wait_n;
   logic        o_slave_bus_grant, o_shared_ram_select_n, o_dsp_store_select_n, o_input_port_a_select_n;
   logic        o_input_port_b_select_n, o_input_port_c_select, o_uart_select_n, o_slave_sync_n;
   logic        o_audio_mute_n, o_slave_reset_n;
   logic [1:0]  o_midi_led;
   int          mismatches = 0, compares = 0;
   mad_master_decoder dut (.*);
   mad_slave_cpu_model slave (.i_core_clk(i_core_clk), .i_slave_reset_n(o_slave_reset_n),
      .o_addr(i_slave_address_bus), .o_mreq_n(i_slave_memory_request_n), .o_refresh_n(i_slave_refresh_n));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Control nibble is {mreq_n, ioreq_n, rd_n, wr_n}, held over one sampling edge
   task automatic cyc(input logic [3:0] c, input logic [15:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      {i_master_memory_request_n, i_master_io_request_n, i_master_rd_n, i_master_wr_n} = c;
      i_master_address_bus = a;
      i_master_data_bus = d;
      @(negedge i_core_clk);
   endtask
   task automatic t_mem();
      logic [15:0] a [12] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hBFFF,
                              16'hC000, 16'hDFFF, 16'hE000, 16'hE3FF, 16'hE400, 16'hFFFF};
      logic [4:0]  e [12] = '{5'h0F, 5'h0F, 5'h1F, 5'h1F, 5'h17, 5'h17, 5'h19, 5'h19, 5'h1A, 5'h1A, 5'h1F, 5'h1F};
      for (int k = 0; k < 12; k++) begin
         cyc(4'h5, a[k], 8'h00);
         chk({o_rom_select_n, o_local_ram_select_n, o_master_slavebus_request_n, o_shared_ram_select_n,
              o_dsp_store_select_n, o_master_wait_n, o_slave_bus_grant}, {e[k], 1'b1, !e[k][2]});
         cyc(4'hF, a[k], 8'h00);
         chk({o_rom_select_n, o_local_ram_select_n, o_master_slavebus_request_n}, 3'h7);
      end
   endtask
   task automatic t_io();
      logic [7:0] a [7] = '{8'h00, 8'h1F, 8'h20, 8'h40, 8'h60, 8'h80, 8'hA0};
      logic [3:0] e [7] = '{4'h5, 4'h5, 4'h9, 4'hF, 4'hD, 4'hC, 4'hD};
      for (int k = 0; k < 7; k++) begin
         cyc(4'h9, {8'h00, a[k]}, 8'h00);
         chk({o_input_port_a_select_n, o_input_port_b_select_n, o_input_port_c_select, o_uart_select_n}, e[k]);
      end
      cyc(4'hA, 16'h0080, 8'h00);
      chk(o_uart_select_n, 1'b0);
      i_master_m1_n = 1'b0;
      cyc(4'h9, 16'h0000, 8'h00);
      chk({o_input_port_a_select_n, o_uart_select_n}, 2'h3);
      i_master_m1_n = 1'b1;
   endtask
   task automatic t_latch();
      cyc(4'hA, 16'h0060, 8'h07);
      cyc(4'hF, 16'h0000, 8'h00);
      chk({o_slave_sync_n, o_audio_mute_n, o_slave_reset_n, o_midi_led}, 5'h1C);
      cyc(4'hA, 16'h0060, 8'h1A);
      cyc(4'h9, 16'h0060, 8'h07);
      cyc(4'hA, 16'h0040, 8'h07);
      cyc(4'hF, 16'h0000, 8'h00);
      chk({o_slave_sync_n, o_audio_mute_n, o_slave_reset_n, o_midi_led}, 5'h0B);
      cyc(4'hA, 16'h007F, 8'h0F);
      cyc(4'hF, 16'h0000, 8'h00);
      chk({o_slave_sync_n, o_audio_mute_n, o_slave_reset_n, o_midi_led}, 5'h1D);
   endtask
   task automatic t_window();
      int   n;
      logic saw_wait;
      n = 0;
      saw_wait = 1'b0;
      // Start just after a refresh so the request must wait for the next one
      @(posedge i_slave_refresh_n);
      cyc(4'h5, 16'hC000, 8'h00);
      do begin
         if (o_master_wait_n === 1'b0) saw_wait = 1'b1;
         @(negedge i_core_clk);
         n++;
      end while (o_slave_bus_grant !== 1'b1 && n < 12);
      chk({saw_wait, o_slave_bus_grant, o_shared_ram_select_n, o_master_wait_n}, 4'hD);
      cyc(4'hF, 16'h0000, 8'h00);
      cyc(4'hF, 16'h0000, 8'h00);
      chk({o_master_wait_n, o_slave_bus_grant}, 2'h2);
   endtask
   task automatic end_of_test();
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      forever #2 i_core_clk = ~i_core_clk;
   end
   initial begin
      repeat (12) @(negedge i_core_clk);
      i_resetn = 1'b1;
      @(negedge i_core_clk);
      chk({o_slave_sync_n, o_audio_mute_n, o_slave_reset_n, o_midi_led, o_master_wait_n, o_slave_bus_grant}, 7'h42);
      t_mem();
      t_io();
      t_latch();
      t_window();
      end_of_test();
   end
   initial begin
      #20000;
      mismatches++;
      end_of_test();
   end
endmodule
bind mad_master_decoder mad_master_decoder_properties u_props (.*);
